/* core/idec_consts.svh */
/*
 * timing-free constants for the instruction execute block: lengths,
 * operand field positions and vector spacing.
 * assumes it is included by its bare name before any user.
 */
// Function
// - word/byte add, subtract, with carry; 2/4 bytes
// - signed/unsigned 16x16 product, 2 bytes
// - signed/unsigned 16/16 divide of low register
// - signed/unsigned 32/16 long divide of pair
// - bit copy, invert, AND/OR/XOR/compare; 4 bytes
// - masked byte modify alters only masked bits
// - compare then decrement register by 1/2
// - compare then increment register by 1/2
// - normalize count written to another register
// - arithmetic shift right replicates sign bit
// - byte to word with sign/zero extension
// - jump if bit set; variant clears bit
// - jump if bit clear; variant sets bit
// - push register then call absolute address
// - push register then load word operand
// - trap number selects service routine vector
// - legacy sleep decodes, length 4, no action
// - init lock ends initialization, locks registers
// - page/segment override prefixes, optional register
// - accumulator load and register store, 4 bytes
// - accumulator negate and coprocessor null operation
`ifndef IDEC_CONSTS_SVH
`define IDEC_CONSTS_SVH
// ************************************************************
// instruction lengths in bytes
// ************************************************************
`define LEN_SHORT   3'h2
`define LEN_LONG    3'h4
// ************************************************************
// operand fields and flag positions
// ************************************************************
`define MASK_LO     0
`define DATA_LO     8
`define FLG_N       3
`define FLG_Z       2
`define FLG_V       1
`define FLG_C       0
`define VEC_SHIFT   2
`define SHAMT_W     4
`endif

/* core/idec_exec.sv */
/*
 * execute stage for one already-fetched instruction per request.
 * assumes the fetch stage supplies operands and an operation code
 * on the same clock; every answer appears one cycle after req.
 */
`timescale 1ns/1ps
`include "idec_consts.svh"
module idec_exec
	import idec_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// request from fetch
	input  wire logic        req,
	input  wire logic [4:0]  opc,
	input  wire logic        wide,
	input  wire logic [1:0]  sub,
	input  wire logic        carry_in,
	input  wire logic [15:0] opa,
	input  wire logic [15:0] opb,
	input  wire logic [31:0] md_in,
	input  wire logic        bit_a,
	input  wire logic        bit_b,
	input  wire logic [6:0]  trap_num,
	// answer
	output logic             done,
	output logic [2:0]       len,
	output logic [15:0]      res,
	output logic [15:0]      aux,
	output logic [31:0]      md_out,
	output logic [3:0]       flags,
	output logic             bit_val,
	output logic             bit_wr,
	output logic             jump,
	output logic             push_en,
	output logic             trap_en,
	output logic [8:0]       vec,
	output logic             ext_en,
	output logic             ext_seg,
	output logic             ext_reg,
	output logic             locked,
	output logic             illegal
);
	// ************************************************************
	// state and helpers
	// ************************************************************
	st_s         s_r;          // registered state
	st_s         s_nxt;        // next state
	op_e         op;           // decoded group
	logic [16:0] ar;           // {carry, result} of add/sub
	logic        ar_v;         // overflow of add/sub
	logic [15:0] dv;           // divisor, never zero
	logic        dz;           // divide by zero

	// normalize count: steps until bit 15 is one
	function automatic logic [15:0] norm_cnt(input logic [15:0] w);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 15; i >= 0; i--) begin
			if (w[i] == 1'b0 && c == 16'(15 - i)) begin
				c = 16'(16 - i);
			end
		end
		return (w == 16'h0000) ? 16'h0000 : c;
	endfunction

	// flags of a word or byte result
	function automatic logic [3:0] mk_flags(input logic [15:0] r, input logic by,
			input logic c, input logic v);
		logic [3:0] f;
		f = 4'h0;
		f[`FLG_N] = by ? r[7] : r[15];
		f[`FLG_Z] = by ? (r[7:0] == 8'h00) : (r == 16'h0000);
		f[`FLG_V] = v;
		f[`FLG_C] = c;
		return f;
	endfunction

	assign op = op_e'(opc);
	assign dz = (opb == 16'h0000);
	assign dv = dz ? 16'h0001 : opb;

	// ************************************************************
	// add and subtract datapath
	// ************************************************************
	// byte forms work on the low lane; the carry from bit 8 is moved to bit 16
	always_comb begin
		logic ci;
		logic is_sub;
		ci = (op == OP_ADDC || op == OP_SUBC) ? carry_in : 1'b0;
		is_sub = (op == OP_SUB || op == OP_SUBC);
		if (sub[0]) begin
			ar = is_sub ? 17'({1'b0, opa[7:0]} - {1'b0, opb[7:0]} - 9'(ci))
			            : 17'({1'b0, opa[7:0]} + {1'b0, opb[7:0]} + 9'(ci));
			ar = {ar[8], 8'h00, ar[7:0]};
			ar_v = is_sub ? ((opa[7] ^ opb[7]) & (opa[7] ^ ar[7]))
			              : (~(opa[7] ^ opb[7]) & (opa[7] ^ ar[7]));
		end else begin
			ar = is_sub ? ({1'b0, opa} - {1'b0, opb} - 17'(ci))
			            : ({1'b0, opa} + {1'b0, opb} + 17'(ci));
			ar_v = is_sub ? ((opa[15] ^ opb[15]) & (opa[15] ^ ar[15]))
			              : (~(opa[15] ^ opb[15]) & (opa[15] ^ ar[15]));
		end
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic [15:0] m;
		logic [7:0]  ln;
		m = 16'h0000;
		ln = 8'h00;
		s_nxt = s_r;
		// pulses drop unless a request renews them
		s_nxt.done = 1'b0;
		s_nxt.bit_wr = 1'b0;
		s_nxt.jump = 1'b0;
		s_nxt.push_en = 1'b0;
		s_nxt.trap_en = 1'b0;
		s_nxt.ext_en = 1'b0;
		s_nxt.illegal = 1'b0;
		if (req) begin
			s_nxt.done = 1'b1;
			s_nxt.len = wide ? `LEN_LONG : `LEN_SHORT;
			case (op)
				// arithmetic, sub[0] selects the byte form
				OP_ADD, OP_ADDC, OP_SUB, OP_SUBC: begin
					s_nxt.res = ar[15:0];
					s_nxt.flags = mk_flags(ar[15:0], sub[0], ar[16], ar_v);
				end
				// product lands in the pair, sub[0] selects unsigned
				OP_MUL: begin
					s_nxt.len = `LEN_SHORT;
					s_nxt.md = sub[0] ? (32'(opa) * 32'(opb))
					                  : 32'($signed(opa) * $signed(opb));
					s_nxt.flags = mk_flags(s_nxt.md[15:0], 1'b0, 1'b0, 1'b0);
				end
				// remainder high, quotient low; zero divisor sets V only
				OP_DIV: begin
					s_nxt.len = `LEN_SHORT;
					if (!dz) begin
						s_nxt.md = sub[0]
							? {md_in[15:0] % dv, md_in[15:0] / dv}
							: {16'($signed(md_in[15:0]) % $signed(dv)),
							   16'($signed(md_in[15:0]) / $signed(dv))};
					end
					s_nxt.flags = {2'b00, dz, 1'b0};
				end
				OP_DIVL: begin
					s_nxt.len = `LEN_SHORT;
					if (!dz) begin
						s_nxt.md = sub[0]
							? {16'(md_in % 32'(dv)), 16'(md_in / 32'(dv))}
							: {16'($signed(md_in) % $signed(dv)),
							   16'($signed(md_in) / $signed(dv))};
					end
					s_nxt.flags = {2'b00, dz, 1'b0};
				end
				// bit a is the source, bit b the destination
				OP_BMOV: begin
					s_nxt.len = `LEN_LONG;
					s_nxt.bit_val = bit_a ^ sub[0];
					s_nxt.bit_wr = 1'b1;
				end
				OP_BLOG: begin
					s_nxt.len = `LEN_LONG;
					case (sub)
						2'h0: s_nxt.bit_val = bit_b & bit_a;
						2'h1: s_nxt.bit_val = bit_b | bit_a;
						2'h2: s_nxt.bit_val = bit_b ^ bit_a;
						default: s_nxt.bit_val = bit_b;
					endcase
					// compare leaves the destination alone
					s_nxt.bit_wr = (sub != 2'h3);
					s_nxt.flags = {1'b0, ~(bit_a ^ bit_b), 2'b00};
				end
				// opb holds mask low and data high; sub[0] picks high lane
				OP_BFLD: begin
					s_nxt.len = `LEN_LONG;
					m = sub[0] ? {opb[`MASK_LO +: 8], 8'h00} : {8'h00, opb[`MASK_LO +: 8]};
					s_nxt.res = (opa & ~m) | (m & (sub[0] ? {opb[`DATA_LO +: 8], 8'h00}
					                                     : {8'h00, opb[`DATA_LO +: 8]}));
					s_nxt.flags = mk_flags(s_nxt.res, 1'b0, 1'b0, 1'b0);
				end
				// compare opa with opb, then step the register in aux
				OP_CMPD, OP_CMPI: begin
					s_nxt.flags = mk_flags(16'(opa - opb), 1'b0, opa < opb,
						(opa[15] ^ opb[15]) & (opa[15] ^ 1'(16'(opa - opb) >> 15)));
					if (op == OP_CMPD) begin
						s_nxt.aux = opa - (sub[0] ? 16'h0002 : 16'h0001);
					end else begin
						s_nxt.aux = opa + (sub[0] ? 16'h0002 : 16'h0001);
					end
				end
				OP_NORMALIZE_COUNT_OP: begin
					s_nxt.len = `LEN_SHORT;
					s_nxt.res = norm_cnt(opa);
					s_nxt.flags = mk_flags(s_nxt.res, 1'b0, 1'b0, 1'b0);
				end
				OP_SIGN_SHIFT_RIGHT: begin
					s_nxt.len = `LEN_SHORT;
					s_nxt.res = 16'($signed(opa) >>> opb[`SHAMT_W-1:0]);
					s_nxt.flags = mk_flags(s_nxt.res, 1'b0, 1'b0, 1'b0);
				end
				// sub[0] high selects zero fill
				OP_MOVBX: begin
					ln = opa[7:0];
					s_nxt.res = {sub[0] ? 8'h00 : {8{ln[7]}}, ln};
					s_nxt.flags = mk_flags(s_nxt.res, 1'b0, 1'b0, 1'b0);
				end
				// sub[0] asks for the bit to be flipped on the way
				OP_JB: begin
					s_nxt.len = `LEN_LONG;
					s_nxt.jump = bit_a;
					s_nxt.bit_val = 1'b0;
					s_nxt.bit_wr = bit_a & sub[0];
				end
				OP_JNB: begin
					s_nxt.len = `LEN_LONG;
					s_nxt.jump = ~bit_a;
					s_nxt.bit_val = 1'b1;
					s_nxt.bit_wr = ~bit_a & sub[0];
				end
				// push value in aux, target in res
				OP_PUSH_AND_CALL_OP: begin
					s_nxt.len = `LEN_LONG;
					s_nxt.aux = opa;
					s_nxt.push_en = 1'b1;
					s_nxt.res = opb;
					s_nxt.jump = 1'b1;
				end
				OP_CONTEXT_SWITCH_OP: begin
					s_nxt.len = `LEN_LONG;
					s_nxt.aux = opa;
					s_nxt.push_en = 1'b1;
					s_nxt.res = opb;
				end
				OP_TRAP: begin
					s_nxt.len = `LEN_SHORT;
					s_nxt.trap_en = 1'b1;
					s_nxt.vec = 9'(trap_num) << `VEC_SHIFT;
				end
				// kept only for code compatibility; deliberately inert
				OP_SLEEP: s_nxt.len = `LEN_LONG;
				// lock holds until reset, nothing unlocks it
				OP_INIT_LOCK_OP: begin
					s_nxt.len = `LEN_LONG;
					s_nxt.locked = 1'b1;
				end
				OP_EXTP, OP_EXTS: begin
					s_nxt.ext_en = 1'b1;
					s_nxt.ext_seg = (op == OP_EXTS);
					s_nxt.ext_reg = sub[0];
				end
				// sub[0] low loads {opa,opb}, high stores acc to res/aux
				OP_MACLS: begin
					s_nxt.len = `LEN_LONG;
					if (sub[0]) begin
						{s_nxt.aux, s_nxt.res} = s_r.acc;
					end else begin
						s_nxt.acc = {opa, opb};
					end
				end
				OP_MACNN: begin
					s_nxt.len = `LEN_LONG;
					if (!sub[0]) begin
						s_nxt.acc = 32'h0000_0000 - s_r.acc;
					end
				end
				OP_NOP: s_nxt.len = `LEN_SHORT;
				// codes beyond the table do nothing but flag
				default: begin
					s_nxt.illegal = 1'b1;
					s_nxt.len = `LEN_SHORT;
				end
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done    = s_r.done;
	assign len     = s_r.len;
	assign res     = s_r.res;
	assign aux     = s_r.aux;
	assign md_out  = s_r.md;
	assign flags   = s_r.flags;
	assign bit_val = s_r.bit_val;
	assign bit_wr  = s_r.bit_wr;
	assign jump    = s_r.jump;
	assign push_en = s_r.push_en;
	assign trap_en = s_r.trap_en;
	assign vec     = s_r.vec;
	assign ext_en  = s_r.ext_en;
	assign ext_seg = s_r.ext_seg;
	assign ext_reg = s_r.ext_reg;
	assign locked  = s_r.locked;
	assign illegal = s_r.illegal;

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_req(op_e k);
		req && op == k;
	endsequence
	a_add_word: assert property (@(posedge clk) disable iff (rst)
		s_req(OP_ADD) ##0 !sub[0] |=> res == 16'($past(opa) + $past(opb)))
		else $error("word add result wrong");
	a_mul_signed: assert property (@(posedge clk) disable iff (rst)
		s_req(OP_MUL) ##0 !sub[0] |=> md_out == 32'($signed($past(opa)) * $signed($past(opb))))
		else $error("signed product wrong");
	a_cmpd_step: assert property (@(posedge clk) disable iff (rst)
		s_req(OP_CMPD) |=> aux == $past(opa) - ($past(sub[0]) ? 16'h0002 : 16'h0001))
		else $error("decrement step wrong");
	a_sign_shift_right_sign: assert property (@(posedge clk) disable iff (rst)
		s_req(OP_SIGN_SHIFT_RIGHT) |=> res[15] == $past(opa[15]))
		else $error("sign bit lost on shift");
	a_jb_taken: assert property (@(posedge clk) disable iff (rst)
		s_req(OP_JB) |=> jump == $past(bit_a) && len == `LEN_LONG)
		else $error("set-bit branch wrong");
	a_push_and_call_op_seq: assert property (@(posedge clk) disable iff (rst)
		s_req(OP_PUSH_AND_CALL_OP) |=> push_en && jump && aux == $past(opa) ##1 (!push_en || $past(req)))
		else $error("push and call wrong");
	a_sleep_inert: assert property (@(posedge clk) disable iff (rst)
		s_req(OP_SLEEP) |=> len == `LEN_LONG && !jump && !push_en && !bit_wr && $stable(locked))
		else $error("legacy sleep had an effect");
	a_lock_stays: assert property (@(posedge clk) disable iff (rst)
		locked |=> locked)
		else $error("init lock released");
	a_trap_vec: assert property (@(posedge clk) disable iff (rst)
		s_req(OP_TRAP) |=> trap_en && vec == (9'($past(trap_num)) << `VEC_SHIFT))
		else $error("trap vector wrong");
endmodule // idec_exec

/* core/idec_pkg.sv */
/*
 * types of the instruction execute block: operation codes and state.
 * assumes idec_consts.svh is on the include path.
 */
package idec_pkg;
	// ************************************************************
	// operation groups, as delivered by the fetch stage
	// ************************************************************
	typedef enum logic [4:0] {
		OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_MUL, OP_DIV, OP_DIVL,
		OP_BMOV, OP_BLOG, OP_BFLD, OP_CMPD, OP_CMPI, OP_NORMALIZE_COUNT_OP, OP_SIGN_SHIFT_RIGHT,
		OP_MOVBX, OP_JB, OP_JNB, OP_PUSH_AND_CALL_OP, OP_CONTEXT_SWITCH_OP, OP_TRAP, OP_SLEEP,
		OP_INIT_LOCK_OP, OP_EXTP, OP_EXTS, OP_MACLS, OP_MACNN, OP_NOP
	} op_e;
	// ************************************************************
	// whole state of the execute block
	// ************************************************************
	typedef struct packed {
		logic        done;
		logic [2:0]  len;
		logic [15:0] res;
		logic [15:0] aux;
		logic [31:0] md;
		logic [3:0]  flags;
		logic        bit_val;
		logic        bit_wr;
		logic        jump;
		logic        push_en;
		logic        trap_en;
		logic [8:0]  vec;
		logic        ext_en;
		logic        ext_seg;
		logic        ext_reg;
		logic        locked;
		logic        illegal;
		logic [31:0] acc;
	} st_s;
endpackage

/* testbench/cpu_instruction_decode_tb_top.sv */
/*
 * self-checking bench for idec_exec: random sweep of every operation
 * code, directed divide by zero, coprocessor accumulator and reset.
 * assumes idec_pkg and idec_consts.svh are compiled before this file.
 */
`timescale 1ns/1ps
module cpu_instruction_decode_tb_top import idec_pkg::*;;
	// ************************************************************
	// design signals
	// ************************************************************
	logic        clk;      // 100 MHz
	logic        rst;      // async, active high
	logic        req;      // request strobe
	logic [4:0]  opc;      // operation group
	logic        wide;     // 4-byte operand form
	logic [1:0]  sub;      // variant
	logic        carry_in; // carry for add/sub
	logic [15:0] opa;      // operand a
	logic [15:0] opb;      // operand b
	logic [31:0] md_in;    // multiply/divide pair
	logic        bit_a;    // source bit
	logic        bit_b;    // destination bit
	logic [6:0]  trap_num; // trap number
	logic        done, bit_val, bit_wr, jump, push_en, trap_en;
	logic        ext_en, ext_seg, ext_reg, locked, illegal;
	logic [2:0]  len;
	logic [15:0] res, aux;
	logic [31:0] md_out;
	logic [3:0]  flags;
	logic [8:0]  vec;
	// bench model state and counters
	logic [31:0] acc_m;    // model accumulator
	logic [31:0] md_m;     // model multiply/divide pair
	logic        lk_m;     // model lock flag
	int          mismatches;
	int          n_tests;
	integer      seed;

	idec_exec dut (.clk(clk), .rst(rst), .req(req), .opc(opc), .wide(wide), .sub(sub),
		.carry_in(carry_in), .opa(opa), .opb(opb), .md_in(md_in), .bit_a(bit_a),
		.bit_b(bit_b), .trap_num(trap_num), .done(done), .len(len), .res(res),
		.aux(aux), .md_out(md_out), .flags(flags), .bit_val(bit_val), .bit_wr(bit_wr),
		.jump(jump), .push_en(push_en), .trap_en(trap_en), .vec(vec), .ext_en(ext_en),
		.ext_seg(ext_seg), .ext_reg(ext_reg), .locked(locked), .illegal(illegal));

	// free-running clock, 10 ns period
	always #5 clk = ~clk;

	// ************************************************************
	// compare, verdict and model
	// ************************************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// expected length; plain null operation is the short one
	function automatic logic [2:0] len_of(input logic [4:0] o, input logic w);
		case (o)
			OP_MUL, OP_DIV, OP_DIVL, OP_NORMALIZE_COUNT_OP, OP_SIGN_SHIFT_RIGHT, OP_TRAP, OP_NOP: return 3'h2;
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMPD, OP_CMPI, OP_MOVBX, OP_EXTP,
			OP_EXTS: return w ? 3'h4 : 3'h2;
			default: return 3'h4;
		endcase
	endfunction

	// one request; operands already driven; answer checked one cycle on
	// req stays high so the next call can follow back to back
	task automatic run(input logic [4:0] o, input logic w, input logic [1:0] s);
		logic [31:0] q;
		logic [15:0] e, m, d;
		logic        tk;
		int          i, ia, ib, ir;
		opc = o;
		wide = w;
		sub = s;
		req = 1'b1;
		@(posedge clk);
		#1;
		chk(done, 1'b1);
		chk(illegal, o > 5'h1A);
		if (o <= 5'h1A) chk(len, len_of(o, w));
		q = md_m;
		case (o)
			// byte forms work on the low lane, upper byte comes back zero
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBC: begin
				ia = s[0] ? opa[7:0] : opa;
				ib = s[0] ? opb[7:0] : opb;
				tk = (o == OP_ADDC || o == OP_SUBC) & carry_in;
				ir = (o == OP_SUB || o == OP_SUBC) ? ia - ib - tk : ia + ib + tk;
				e = s[0] ? {8'h00, ir[7:0]} : ir[15:0];
				chk(res, e);
				chk(flags[0], s[0] ? ir[8] : ir[16]);
				chk(flags[2], e == 16'h0000);
			end
			// if/else keeps the signed product from being zero extended
			OP_MUL: begin
				if (s[0]) q = opa * opb;
				else q = $signed(opa) * $signed(opb);
			end
			OP_DIV, OP_DIVL: begin
				if (opb == 16'h0000) chk(flags, 4'h2);
				else if (o == OP_DIV)
					q = s[0] ? {md_in[15:0] % opb, md_in[15:0] / opb} :
						{$signed(md_in[15:0]) % $signed(opb), $signed(md_in[15:0]) / $signed(opb)};
				else if (s[0])
					q = {16'(md_in % opb), 16'(md_in / opb)};
				else
					q = {16'($signed(md_in) % $signed(opb)), 16'($signed(md_in) / $signed(opb))};
			end
			OP_BMOV: chk(bit_val, bit_a ^ s[0]);
			OP_BLOG: begin
				tk = (s == 2'h0) ? bit_a & bit_b : (s == 2'h1) ? bit_a | bit_b : bit_a ^ bit_b;
				if (s != 2'h3) chk(bit_val, tk);
				chk(bit_wr, s != 2'h3);
				chk(flags[2], bit_a == bit_b);
			end
			OP_BFLD: begin
				m = s[0] ? {opb[7:0], 8'h00} : {8'h00, opb[7:0]};
				d = s[0] ? {opb[15:8], 8'h00} : {8'h00, opb[15:8]};
				e = (opa & ~m) | (d & m);
				chk(res, e);
			end
			OP_CMPD, OP_CMPI: begin
				e = (o == OP_CMPD) ? opa - (s[0] ? 16'h2 : 16'h1) : opa + (s[0] ? 16'h2 : 16'h1);
				chk(aux, e);
				chk(flags[0], opa < opb);
			end
			OP_NORMALIZE_COUNT_OP: begin
				i = 0;
				if (opa != 16'h0000) while (!opa[15 - i]) i++;
				chk(res, i);
			end
			OP_SIGN_SHIFT_RIGHT: begin e = $signed(opa) >>> opb[3:0]; chk(res, e); end
			OP_MOVBX: begin
				e = s[0] ? {8'h00, opa[7:0]} : {{8{opa[7]}}, opa[7:0]};
				chk(res, e);
			end
			OP_JB, OP_JNB: begin
				tk = bit_a ^ (o == OP_JNB);
				chk(jump, tk);
				chk(bit_wr, tk & s[0]);
				if (tk & s[0]) chk(bit_val, o == OP_JNB);
			end
			OP_PUSH_AND_CALL_OP, OP_CONTEXT_SWITCH_OP: begin
				chk(aux, opa);
				chk(res, opb);
			end
			OP_TRAP: chk(vec, {trap_num, 2'b00});
			OP_INIT_LOCK_OP: lk_m = 1'b1;
			OP_EXTP, OP_EXTS: begin
				chk(ext_seg, o == OP_EXTS);
				chk(ext_reg, s[0]);
			end
			OP_MACLS: if (s[0]) chk({aux, res}, acc_m); else acc_m = {opa, opb};
			OP_MACNN: if (!s[0]) acc_m = -acc_m;
			default: ;
		endcase
		md_m = q;
		chk(md_out, md_m);
		chk(locked, lk_m);
		chk(ext_en, o == OP_EXTP || o == OP_EXTS);
		chk(trap_en, o == OP_TRAP);
		if (o != OP_TRAP) chk(push_en, o == OP_PUSH_AND_CALL_OP || o == OP_CONTEXT_SWITCH_OP);
		if (o != OP_TRAP && o != OP_JB && o != OP_JNB) chk(jump, o == OP_PUSH_AND_CALL_OP);
	endtask

	// ************************************************************
	// stimulus
	// ************************************************************
	initial begin
		clk = 0; rst = 1; req = 0; opc = 0; wide = 0; sub = 0; carry_in = 0;
		opa = 0; opb = 0; md_in = 0; bit_a = 0; bit_b = 0; trap_num = 0;
		acc_m = 0; md_m = 0; lk_m = 0; mismatches = 0; n_tests = 0; seed = 98;
		repeat (16) @(posedge clk);
		#1;
		rst = 0;
		// every code, legal and not, with random operands, back to back
		for (int p = 0; p < 4; p++)
			for (int k = 0; k < 32; k++) begin
				{opa, opb} = $random(seed);
				md_in = $random(seed);
				{carry_in, bit_a, bit_b, trap_num} = 10'($random(seed));
				if (k == OP_INIT_LOCK_OP && p < 3) run(OP_NOP, 1'b0, 2'h0);
				else run(5'(k), p[0], (k < 4) ? {1'b0, p[1]} : 2'(p));
			end
		$display("random sweep done");
		// divide by zero keeps the pair; signed and unsigned forms
		opb = 16'h0000;
		for (int k = 0; k < 4; k++) run(k[1] ? OP_DIVL : OP_DIV, 1'b0, {1'b0, k[0]});
		$display("divide by zero done");
		// accumulator load, negate, null, store
		opa = 16'h1234; opb = 16'h5678;
		run(OP_MACLS, 1'b0, 2'h0);
		run(OP_MACNN, 1'b0, 2'h0);
		run(OP_MACNN, 1'b0, 2'h1);
		run(OP_MACLS, 1'b0, 2'h1);
		run(OP_SLEEP, 1'b0, 2'h0);
		run(OP_INIT_LOCK_OP, 1'b0, 2'h0);
		req = 0;
		$display("accumulator done");
		// reset in mid-run clears done, len, res, md_out and the lock
		@(posedge clk);
		#1;
		rst = 1;
		@(posedge clk);
		#1;
		chk({done, len, res, locked}, 32'h0);
		chk(md_out, 32'h0);
		rst = 0;
		acc_m = 0; md_m = 0; lk_m = 0;
		run(OP_MACLS, 1'b0, 2'h1);
		req = 0;
		$display("reset done");
		tally_and_finish;
	end

	// watchdog; the run needs about 160 cycles
	initial begin
		#50000;
		mismatches++;
		tally_and_finish;
	end
endmodule // cpu_instruction_decode_tb_top
